/* rtl/hmvip_backplane_port.sv */
// Common multiplexed backplane port: shared clocks, frame pulse, receive outputs
//
// Functional notes
// - All multiplexed streams timed to common bit clock
// - Each direction enables all three streams together
// - Both directions off: common clocks, pulse ignored
// - Frame pulse sampled on frame clock falling edge
// - Receive mux data carries four lines' channels
// - Receive outputs update every used rise
// - Common signaling: T1 CCS, E1 slots 15/16/31
// - Shared pin: mux data, optional CCS, else low
// - Associated signaling aligned with mux data slots
// - Associated pin shows line one data by default
// - Transmit mux inputs sampled every second rise
`default_nettype none
module hmvip_backplane_port
    import hmvip_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = FRAME_TIMEOUT
) (
    // Clock and reset
    input  wire logic            core_clk_i,
    input  wire logic            srst_i,
    // Configuration
    input  var  rx_mode_t        rx_mode_i,
    input  wire logic            tx_mux_en_i,
    input  wire logic            e1_mode_i,
    input  wire logic            ccs_full_en_i,
    // Backplane pins, inputs
    input  wire logic            common_bit_clock_i,
    input  wire logic            frame_pulse_clock_i,
    input  wire logic            common_frame_pulse_n_i,
    input  wire logic            tx_muxed_channel_data_i,
    input  wire logic            tx_assoc_signaling_in_i,
    input  wire logic            tx_common_signaling_in_i,
    // Backplane pins, outputs
    output logic                 rx_muxed_channel_data_o,
    output logic                 rx_assoc_signaling_out_o,
    output logic                 rx_common_signaling_out_o,
    // Receive source side
    input  wire logic            rx_line_backplane_data_i,
    input  var  slot_bits_t      rx_src_i,
    output logic [SLOT_W-1:0]    rx_next_slot_o,
    output logic                 rx_slot_take_o,
    // Transmit sink side
    output slot_bits_t           tx_bits_o,
    output logic [SLOT_W-1:0]    tx_slot_o,
    output logic                 tx_valid_o,
    output logic                 tx_line_data_o,
    // Status
    output logic [SLOT_W-1:0]    slot_o,
    output logic                 frame_start_o,
    output logic                 align_err_o,
    output logic                 frame_absent_o
);
    link_in_t          pins_raw;
    link_in_t          pins;
    logic [LINK_IN_W-1:0] pins_vec;

    assign pins_raw.bit_clk = common_bit_clock_i;
    assign pins_raw.fp_clk  = frame_pulse_clock_i;
    assign pins_raw.frame_n = common_frame_pulse_n_i;
    assign pins_raw.tx.data = tx_muxed_channel_data_i;
    assign pins_raw.tx.cas  = tx_assoc_signaling_in_i;
    assign pins_raw.tx.ccs  = tx_common_signaling_in_i;

    hmvip_sync #(
        .WIDTH (LINK_IN_W)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .async_i    (pins_raw),
        .sync_o     (pins_vec)
    );
    assign pins = link_in_t'(pins_vec);

    // Mode decode
    logic rx_mux;
    logic any_mux;
    assign rx_mux  = (rx_mode_i == RX_MODE_SLAVE_MUX);
    assign any_mux = rx_mux | tx_mux_en_i;

    // Edge detection and slot timing state
    logic              bit_clk_q;
    logic              bit_clk_d;
    logic              fp_clk_q;
    logic              fp_clk_d;
    logic              phase_q;
    logic              phase_d;
    logic              restart_q;
    logic              restart_d;
    logic              seen_q;
    logic              seen_d;
    logic [SLOT_W-1:0] slot_q;
    logic [SLOT_W-1:0] slot_d;
    logic              fstart_q;
    logic              fstart_d;
    logic              aerr_q;
    logic              aerr_d;
    logic [WD_W-1:0]   wd_q;
    logic [WD_W-1:0]   wd_d;
    logic              absent_q;
    logic              absent_d;

    logic              bit_rise;
    logic              fp_fall;
    logic              phase_now;
    logic              used_edge;
    logic              pulse_seen;
    logic [SLOT_W-1:0] next_slot;

    always_comb begin
        bit_rise   = pins.bit_clk & ~bit_clk_q;
        fp_fall    = ~pins.fp_clk & fp_clk_q;
        // Frame clock fall fixes the phase of the used bit clock rises
        phase_now  = fp_fall ? 1'b0 : phase_q;
        used_edge  = any_mux & bit_rise & ~phase_now;
        pulse_seen = any_mux & fp_fall & ~pins.frame_n;
        next_slot  = restart_q ? SLOT_FIRST : slot_q + SLOT_ONE;

        bit_clk_d  = pins.bit_clk;
        fp_clk_d   = pins.fp_clk;
        phase_d    = phase_q;
        restart_d  = restart_q;
        seen_d     = seen_q;
        slot_d     = slot_q;
        fstart_d   = 1'b0;
        aerr_d     = 1'b0;
        wd_d       = wd_q;
        absent_d   = absent_q;

        if (any_mux) begin
            phase_d = bit_rise ? ~phase_now : phase_now;
        end
        if (used_edge) begin
            slot_d    = next_slot;
            restart_d = 1'b0;
            fstart_d  = restart_q;
            aerr_d    = seen_q & ~restart_q & (slot_q == SLOT_LAST);
        end
        if (pulse_seen) begin
            restart_d = 1'b1;
            seen_d    = 1'b1;
        end
        // Watchdog for a missing frame pulse
        if (!any_mux) begin
            wd_d     = '0;
            absent_d = 1'b0;
        end else if (pulse_seen) begin
            wd_d     = '0;
            absent_d = 1'b0;
        end else if (wd_q >= WD_W'(TIMEOUT_CYC)) begin
            absent_d = 1'b1;
        end else begin
            wd_d     = wd_q + WD_W'(1);
        end

        if (srst_i) begin
            bit_clk_d = 1'b0;
            fp_clk_d  = 1'b0;
            phase_d   = 1'b0;
            restart_d = 1'b0;
            seen_d    = 1'b0;
            slot_d    = SLOT_FIRST;
            fstart_d  = 1'b0;
            aerr_d    = 1'b0;
            wd_d      = '0;
            absent_d  = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        bit_clk_q <= bit_clk_d;
        fp_clk_q  <= fp_clk_d;
        phase_q   <= phase_d;
        restart_q <= restart_d;
        seen_q    <= seen_d;
        slot_q    <= slot_d;
        fstart_q  <= fstart_d;
        aerr_q    <= aerr_d;
        wd_q      <= wd_d;
        absent_q  <= absent_d;
    end

    // Common signaling slot selection
    logic [4:0] next_ts;
    logic       ccs_keep;

    always_comb begin
        next_ts  = next_slot[TS_MSB:TS_LSB];
        if (e1_mode_i) begin
            ccs_keep = (next_ts == E1_CCS_TS_A) | (next_ts == E1_CCS_TS_B)
                     | (next_ts == E1_CCS_TS_C);
        end else begin
            ccs_keep = (next_ts == T1_CCS_TS);
        end
    end

    // Receive output state
    slot_bits_t rx_q;
    slot_bits_t rx_d;
    logic       mux_pin_q;
    logic       mux_pin_d;
    logic       cas_pin_q;
    logic       cas_pin_d;
    logic       ccs_pin_q;
    logic       ccs_pin_d;

    always_comb begin
        rx_d = rx_q;
        if (used_edge && rx_mux) begin
            rx_d.data = rx_src_i.data;
            rx_d.cas  = rx_src_i.cas;
            rx_d.ccs  = rx_src_i.ccs & ccs_keep;
        end else if (!rx_mux && (rx_mode_i != RX_MODE_SLAVE_FULL)) begin
            rx_d = '0;
        end else if (used_edge) begin
            rx_d.ccs = rx_src_i.ccs & ccs_keep;
        end

        // Pin selection by receive mode
        if (rx_mux) begin
            mux_pin_d = rx_d.data;
        end else if ((rx_mode_i == RX_MODE_SLAVE_FULL) && ccs_full_en_i) begin
            mux_pin_d = rx_d.ccs;
        end else begin
            mux_pin_d = 1'b0;
        end

        cas_pin_d = rx_mux ? rx_d.cas : rx_line_backplane_data_i;
        ccs_pin_d = rx_mux ? rx_d.ccs : 1'b0;

        if (srst_i) begin
            rx_d      = '0;
            mux_pin_d = 1'b0;
            cas_pin_d = 1'b0;
            ccs_pin_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        rx_q      <= rx_d;
        mux_pin_q <= mux_pin_d;
        cas_pin_q <= cas_pin_d;
        ccs_pin_q <= ccs_pin_d;
    end

    // Transmit capture state
    slot_bits_t        tx_q;
    slot_bits_t        tx_d;
    logic [SLOT_W-1:0] tx_slot_q;
    logic [SLOT_W-1:0] tx_slot_d;
    logic              tx_vld_q;
    logic              tx_vld_d;
    logic              tx_ln_q;
    logic              tx_ln_d;

    always_comb begin
        tx_d      = tx_q;
        tx_slot_d = tx_slot_q;
        tx_vld_d  = 1'b0;
        tx_ln_d   = tx_mux_en_i ? 1'b0 : pins.tx.cas;
        if (used_edge && tx_mux_en_i) begin
            tx_d      = pins.tx;
            tx_slot_d = next_slot;
            tx_vld_d  = 1'b1;
        end
        if (srst_i) begin
            tx_d      = '0;
            tx_slot_d = SLOT_FIRST;
            tx_vld_d  = 1'b0;
            tx_ln_d   = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        tx_q      <= tx_d;
        tx_slot_q <= tx_slot_d;
        tx_vld_q  <= tx_vld_d;
        tx_ln_q   <= tx_ln_d;
    end

    // Outputs
    assign rx_muxed_channel_data_o   = mux_pin_q;
    assign rx_assoc_signaling_out_o  = cas_pin_q;
    assign rx_common_signaling_out_o = ccs_pin_q;
    assign rx_next_slot_o            = next_slot;
    assign rx_slot_take_o            = used_edge;
    assign tx_bits_o                 = tx_q;
    assign tx_slot_o                 = tx_slot_q;
    assign tx_valid_o                = tx_vld_q;
    assign tx_line_data_o            = tx_ln_q;
    assign slot_o                    = slot_q;
    assign frame_start_o             = fstart_q;
    assign align_err_o               = aerr_q;
    assign frame_absent_o            = absent_q;
endmodule : hmvip_backplane_port
`default_nettype wire

/* rtl/hmvip_pkg.sv */
// Shared constants and carrier types for the multiplexed backplane port
`default_nettype none
package hmvip_pkg;
    // Frame layout
    localparam int unsigned SLOT_W        = 10;
    localparam int unsigned SLOTS         = 1024;
    localparam logic [9:0]  SLOT_FIRST    = 10'h000;
    localparam logic [9:0]  SLOT_LAST     = 10'h3ff;
    localparam logic [9:0]  SLOT_ONE      = 10'h001;
    // Slot index fields: timeslot in [9:5], line in [4:3], bit in [2:0]
    localparam int unsigned TS_MSB        = 9;
    localparam int unsigned TS_LSB        = 5;
    localparam int unsigned LINE_MSB      = 4;
    localparam int unsigned LINE_LSB      = 3;
    // Common signaling timeslots
    localparam logic [4:0]  T1_CCS_TS     = 5'h17;
    localparam logic [4:0]  E1_CCS_TS_A   = 5'h0f;
    localparam logic [4:0]  E1_CCS_TS_B   = 5'h10;
    localparam logic [4:0]  E1_CCS_TS_C   = 5'h1f;
    // Timing
    localparam int unsigned CORE_CLK_KHZ  = 25000;
    localparam int unsigned FRAME_US      = 125;
    localparam int unsigned FRAME_CYCLES  = (FRAME_US * CORE_CLK_KHZ) / 1000;
    localparam int unsigned FRAME_TIMEOUT = 2 * FRAME_CYCLES;
    localparam int unsigned WD_W          = 16;
    // Synchroniser depth
    localparam int unsigned SYNC_STAGES   = 2;

    // Receive access modes of the backplane side
    typedef enum logic [1:0] {
        RX_MODE_OTHER      = 2'b00,
        RX_MODE_SLAVE_FULL = 2'b01,
        RX_MODE_SLAVE_MUX  = 2'b11
    } rx_mode_t;

    // One bit slot of channel data and signaling
    typedef struct packed {
        logic data;
        logic cas;
        logic ccs;
    } slot_bits_t;

    // Inputs arriving from the backplane pins
    typedef struct packed {
        logic       bit_clk;
        logic       fp_clk;
        logic       frame_n;
        slot_bits_t tx;
    } link_in_t;

    localparam int unsigned LINK_IN_W = $bits(link_in_t);
endpackage : hmvip_pkg
`default_nettype wire

/* rtl/hmvip_sync.sv */
// Two flip-flop synchroniser for a bundle of asynchronous levels
`default_nettype none
module hmvip_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             srst_i,
    // Levels
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = async_i;
        sync_d = meta_q;
        if (srst_i) begin
            meta_d = '0;
            sync_d = '0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        meta_q <= meta_d;
        sync_q <= sync_d;
    end

    assign sync_o = sync_q;
endmodule : hmvip_sync
`default_nettype wire

/* verification/hmvip_backplane_port_properties.sv */
// Checker for the multiplexed backplane port outputs
`default_nettype none
module hmvip_port_checker
    import hmvip_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = FRAME_TIMEOUT
) (
    // Clock, reset, configuration
    input wire logic              core_clk_i,
    input wire logic              srst_i,
    input var  rx_mode_t          rx_mode_i,
    input wire logic              tx_mux_en_i,
    input wire logic              e1_mode_i,
    input var  slot_bits_t        rx_src_i,
    // Observed outputs
    input wire logic [SLOT_W-1:0] rx_next_slot_o,
    input wire logic [SLOT_W-1:0] slot_o,
    input wire logic [SLOT_W-1:0] tx_slot_o,
    input wire logic              rx_slot_take_o,
    input wire logic              tx_valid_o,
    input wire logic              frame_start_o,
    input wire logic              frame_absent_o,
    input wire logic              rx_muxed_channel_data_o,
    input wire logic              rx_assoc_signaling_out_o,
    input wire logic              rx_common_signaling_out_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] ts;
    logic       ccs_ts;
    assign ts = rx_next_slot_o[TS_MSB:TS_LSB];
    assign ccs_ts = e1_mode_i ? (ts == 5'h0f || ts == 5'h10 || ts == 5'h1f) : (ts == 5'h17);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    sequence mux_take;
        rx_slot_take_o && rx_mode_i == RX_MODE_SLAVE_MUX;
    endsequence
    sequence other_take;
        rx_slot_take_o && rx_mode_i != RX_MODE_SLAVE_MUX;
    endsequence
    take_gate_a: assert property (
        rx_slot_take_o |-> rx_mode_i == RX_MODE_SLAVE_MUX || tx_mux_en_i)
        else $error("used edge while both directions off");
    slot_hold_a: assert property (!rx_slot_take_o |=> $stable(slot_o))
        else $error("slot moved without used edge");
    slot_step_a: assert property (rx_slot_take_o |=> slot_o == $past(rx_next_slot_o))
        else $error("slot not taken from next slot");
    next_slot_a: assert property (
        rx_next_slot_o != SLOT_FIRST |-> rx_next_slot_o == slot_o + SLOT_ONE)
        else $error("next slot not one ahead");
    start_zero_a: assert property (
        frame_start_o |-> slot_o == SLOT_FIRST && $past(rx_slot_take_o))
        else $error("frame start off slot zero");
    tx_sample_a: assert property (
        rx_slot_take_o && tx_mux_en_i |=> tx_valid_o && tx_slot_o == slot_o ##1 !tx_valid_o)
        else $error("transmit capture wrong");
    mux_data_a: assert property (
        mux_take |=> rx_muxed_channel_data_o == $past(rx_src_i.data)
            && rx_assoc_signaling_out_o == $past(rx_src_i.cas))
        else $error("mux data or assoc wrong");
    ccs_slot_a: assert property (
        mux_take |=> rx_common_signaling_out_o == ($past(rx_src_i.ccs) && $past(ccs_ts)))
        else $error("common signaling slot wrong");
    ccs_low_a: assert property (other_take |=> !rx_common_signaling_out_o)
        else $error("common signaling not low");
    mux_low_a: assert property (
        other_take and rx_mode_i != RX_MODE_SLAVE_FULL |=> !rx_muxed_channel_data_o)
        else $error("shared pin not low");
    absent_clear_a: assert property (
        rx_mode_i != RX_MODE_SLAVE_MUX && !tx_mux_en_i |-> ##[1:2] !frame_absent_o)
        else $error("watchdog not cleared");
endmodule : hmvip_port_checker
bind hmvip_backplane_port hmvip_port_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk (.core_clk_i, .srst_i,
    .rx_mode_i, .tx_mux_en_i, .e1_mode_i, .rx_src_i, .rx_next_slot_o, .slot_o, .tx_slot_o,
    .rx_slot_take_o, .tx_valid_o, .frame_start_o, .frame_absent_o, .rx_muxed_channel_data_o,
    .rx_assoc_signaling_out_o, .rx_common_signaling_out_o);
`default_nettype wire

/* verification/hmvip_far_side.sv */
// Far side model: common clocks, frame pulse and transmit streams
`default_nettype none
module hmvip_far_side (
    // Control
    input  wire logic  run_i,
    input  wire logic  pulse_en_i,
    // Backplane pins
    output logic       bit_clk_o,
    output logic       fp_clk_o,
    output logic       frame_n_o,
    output logic       tx_data_o,
    output logic       tx_cas_o,
    output logic       tx_ccs_o,
    output logic [9:0] slot_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [10:0] cnt;
    initial begin
        {bit_clk_o, fp_clk_o, frame_n_o, tx_data_o, tx_cas_o, tx_ccs_o} = 6'h08;
        cnt = 11'h7f8;
        slot_o = 10'h3fc;
        forever begin
            if (!run_i) begin
                #160;
            end else begin
                bit_clk_o = 1'b0;
                if (cnt[1:0] == 2'h0) fp_clk_o = 1'b0;
                if (cnt[1:0] == 2'h2) fp_clk_o = 1'b1;
                frame_n_o = !(pulse_en_i && (cnt[10:1] == 10'h3ff || cnt[10:1] == 10'h000));
                if (!cnt[0]) begin
                    slot_o = cnt[10:1];
                    {tx_data_o, tx_cas_o, tx_ccs_o} = {slot_o[0] ^ slot_o[5], slot_o[1], slot_o[3]};
                end
                #160 bit_clk_o = 1'b1;
                #160 cnt = cnt + 11'h001;
            end
        end
    end
endmodule : hmvip_far_side
`default_nettype wire

/* verification/hmvip_backplane_port_bench.sv */
// Testbench: far side model, reference model and scenario sequence
`default_nettype none
module hmvip_backplane_port_bench;
    import hmvip_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [63:0] TAB = 64'h6cc7_7580_dddd_dddd;
    logic core_clk_i, srst_i, tx_mux_en_i, e1_mode_i, ccs_full_en_i, rx_line_backplane_data_i;
    logic common_bit_clock_i, frame_pulse_clock_i, common_frame_pulse_n_i;
    logic tx_muxed_channel_data_i, tx_assoc_signaling_in_i, tx_common_signaling_in_i;
    logic rx_muxed_channel_data_o, rx_assoc_signaling_out_o, rx_common_signaling_out_o;
    logic rx_slot_take_o, tx_valid_o, frame_start_o, align_err_o, frame_absent_o;
    logic tx_line_data_o, ln_exp;
    logic [2:0] cas_dly;
    logic run, pulse_en, chk, pend, cc;
    rx_mode_t rx_mode_i;
    slot_bits_t rx_src_i, tx_bits_o;
    logic [9:0] rx_next_slot_o, tx_slot_o, slot_o, far_slot, s;
    logic [27:0] exp_v;
    logic [4:0] ts;
    int bad_count, comparisons, takes, errs, i;
    hmvip_far_side far (.run_i(run), .pulse_en_i(pulse_en), .bit_clk_o(common_bit_clock_i),
        .fp_clk_o(frame_pulse_clock_i), .frame_n_o(common_frame_pulse_n_i),
        .tx_data_o(tx_muxed_channel_data_i), .tx_cas_o(tx_assoc_signaling_in_i),
        .tx_ccs_o(tx_common_signaling_in_i), .slot_o(far_slot));
    hmvip_backplane_port #(.TIMEOUT_CYC(20000)) dut (.core_clk_i, .srst_i, .rx_mode_i,
        .tx_mux_en_i, .e1_mode_i, .ccs_full_en_i, .common_bit_clock_i, .frame_pulse_clock_i,
        .common_frame_pulse_n_i, .tx_muxed_channel_data_i, .tx_assoc_signaling_in_i,
        .tx_common_signaling_in_i, .rx_muxed_channel_data_o, .rx_assoc_signaling_out_o,
        .rx_common_signaling_out_o, .rx_line_backplane_data_i, .rx_src_i, .rx_next_slot_o,
        .rx_slot_take_o, .tx_bits_o, .tx_slot_o, .tx_valid_o, .tx_line_data_o, .slot_o,
        .frame_start_o, .align_err_o, .frame_absent_o);
    task automatic check(input logic [27:0] got, input logic [27:0] want);
        comparisons++;
        if (got !== want) begin
            bad_count++;
            $display("[ERR] %0t got %h want %h", $time, got, want);
        end
    endtask : check
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test
    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        #1;
        rx_src_i = slot_bits_t'(3'($urandom));
        rx_line_backplane_data_i = 1'($urandom);
    end
    // Transmit line pin: two sync stages plus one register, zero while muxed
    always @(posedge core_clk_i) begin
        cas_dly <= {cas_dly[1:0], tx_assoc_signaling_in_i};
        ln_exp <= tx_mux_en_i ? 1'b0 : cas_dly[1];
    end
    // Reference model, sampled at the falling edge
    always @(negedge core_clk_i) begin
        if (chk && pend) begin
            check({slot_o, tx_slot_o, frame_start_o, tx_valid_o, rx_muxed_channel_data_o,
                rx_assoc_signaling_out_o, rx_common_signaling_out_o, tx_bits_o},
                exp_v);
        end
        pend = 1'b0;
        if (rx_slot_take_o) begin
            takes++;
            pend = 1'b1;
            s = far_slot;
            ts = s[9:5];
            cc = e1_mode_i ? (ts == 5'h0f || ts == 5'h10 || ts == 5'h1f) : (ts == 5'h17);
            exp_v = {s, s, s == 10'h000, 1'b1, 3'h0, s[0] ^ s[5], s[1], s[3]};
            if (rx_mode_i == RX_MODE_SLAVE_MUX) begin
                exp_v[5:3] = {rx_src_i.data, rx_src_i.cas, rx_src_i.ccs & cc};
            end else begin
                exp_v[5:3] = {rx_mode_i == RX_MODE_SLAVE_FULL && ccs_full_en_i && rx_src_i.ccs
                    && cc, rx_line_backplane_data_i, 1'b0};
            end
            if (chk) check(28'(rx_next_slot_o), 28'(s));
        end
        if (align_err_o) errs++;
        if (chk) check(28'(tx_line_data_o), 28'(ln_exp));
    end
    initial begin
        void'($urandom(32'h73ad2fda));
        {srst_i, run, pulse_en, chk, pend, tx_mux_en_i, e1_mode_i, ccs_full_en_i} = 8'he6;
        rx_mode_i = RX_MODE_SLAVE_MUX;
        rx_src_i = '0;
        rx_line_backplane_data_i = 1'b0;
        repeat (5) @(posedge core_clk_i);
        #1 srst_i = 1'b0;
        for (i = 0; i < 20000 && frame_start_o !== 1'b1; i++) begin
            @(posedge core_clk_i);
            #1;
        end
        check(28'(frame_start_o), 28'h1);
        chk = 1'b1;
        for (i = 0; i < 16; i++) begin
            rx_mode_i = rx_mode_t'(TAB[i*4+2 +: 2]);
            {ccs_full_en_i, e1_mode_i} = TAB[i*4 +: 2];
            repeat (2048) @(posedge core_clk_i);
            #1;
        end
        check(28'(errs), 28'h0);
        $display("mode sweep done");
        rx_mode_i = RX_MODE_OTHER;
        tx_mux_en_i = 1'b0;
        @(posedge core_clk_i);
        #1 s = slot_o;
        i = takes;
        repeat (3000) @(posedge core_clk_i);
        #1 check(28'(takes - i), 28'h0);
        check(28'({slot_o, frame_absent_o}), 28'({s, 1'b0}));
        $display("both directions off done");
        {chk, pulse_en, tx_mux_en_i} = 3'b001;
        rx_mode_i = RX_MODE_SLAVE_MUX;
        errs = 0;
        repeat (21000) @(posedge core_clk_i);
        #1 check(28'({frame_absent_o, errs != 0}), 28'h3);
        $display("missing pulse done");
        stop_test();
    end
    initial begin
        #3_000_000;
        bad_count++;
        stop_test();
    end
endmodule : hmvip_backplane_port_bench
`default_nettype wire
